// file: shp_host_map.vh
`ifndef SHP_HOST_MAP_VH
`define SHP_HOST_MAP_VH

// software-facing register offsets (byte addresses, one word each)
`define SHP_REG_CMD        8'h00
`define SHP_REG_STATUS     8'h04
`define SHP_REG_DIV        8'h08
`define SHP_REG_BUFIDX     8'h0c
`define SHP_REG_BUFDATA    8'h10

// command register fields
`define SHP_CMD_START      0
`define SHP_CMD_WRITE      1
`define SHP_CMD_ADDR_LO    8
`define SHP_CMD_ADDR_HI    14
`define SHP_CMD_WORDS_LO   16
`define SHP_CMD_WORDS_HI   20

// status register fields
`define SHP_ST_BUSY        0
`define SHP_ST_DONE        1
`define SHP_ST_REFUSED     2
`define SHP_ST_PTR_LO      8
`define SHP_ST_PTR_HI      14
`define SHP_ST_MODE_LO     16
`define SHP_ST_MODE_HI     17
`define SHP_ST_CLKEN       18

// device register map seen over the serial link
`define SHP_DEV_STATUS     7'h00
`define SHP_DEV_MODE       7'h10
`define SHP_DEV_FIFO_CFG   7'h11
`define SHP_DEV_SCLK_CTRL  7'h4b
`define SHP_DEV_HOLD_A     7'h5f
`define SHP_DEV_FIFO_PORT  7'h60
`define SHP_DEV_HOLD_B     7'h7f
`define SHP_DEV_CLKEN_BIT  7
`define SHP_DEV_FCLR_BIT   15

// device operating modes
`define SHP_MODE_STANDBY   2'h0
`define SHP_MODE_PROGRAM   2'h1
`define SHP_MODE_NORMAL    2'h2

// serial clock timing
`define SHP_SYS_HZ         250000000
`define SHP_SCLK_MAX_HZ    10000000
`define SHP_HALF_MIN       ((`SHP_SYS_HZ + 2 * `SHP_SCLK_MAX_HZ - 1) / (2 * `SHP_SCLK_MAX_HZ))

// buffer geometry
`define SHP_BUF_WORDS      16
`define SHP_BUF_AW         4

`endif

// file: shp_word_mem.v
`default_nettype none

module shp_word_mem (
  // clocking
  input  wire        sysClk,
  input  wire        clkEn,
  // write port
  input  wire        wrEn,
  input  wire [3:0]  wrAddr,
  input  wire [15:0] wrData,
  // read port, registered
  input  wire [3:0]  rdAddr,
  output reg  [15:0] rdData
);

  reg [15:0] words [0:15];

  // storage and registered read
  always @(posedge sysClk) begin
    if (clkEn) begin
      if (wrEn) begin
        words[wrAddr] <= wrData;
      end
      rdData <= words[rdAddr];
    end
  end

endmodule

`default_nettype wire

// file: shp_sclk_gen.v
`default_nettype none

module shp_sclk_gen (
  // clocking
  input  wire       sysClk,
  input  wire       resetN,
  input  wire       clkEn,
  // control
  input  wire       run,
  input  wire [7:0] halfPeriod,
  // one pulse per serial clock half period
  output reg        tick
);

  reg [7:0] count;

  // half-period counter, restarts whenever idle
  always @(posedge sysClk) begin
    if (!resetN) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (clkEn) begin
      if (!run) begin
        count <= 8'h00;
        tick  <= 1'b0;
      end else if (count >= halfPeriod - 8'h01) begin
        count <= 8'h00;
        tick  <= 1'b1;
      end else begin
        count <= count + 8'h01;
        tick  <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: shp_host_ctrl.v
// Chosen here: register access over APB.
`include "shp_host_map.vh"
`default_nettype none

module shp_host_ctrl (
  // clock, reset, enable
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        clkEn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // serial link to the device
  output reg         spiCsN,
  output reg         spiSclk,
  output reg         spiMosi,
  input  wire        spiMiso
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_LEAD  = 3'h1;
  localparam ST_SHIFT = 3'h2;
  localparam ST_TAIL  = 3'h3;
  localparam ST_GAP   = 3'h4;

  localparam integer HALF_MIN_WIDE = `SHP_HALF_MIN;
  localparam [7:0]   HALF_MIN      = HALF_MIN_WIDE[7:0];

  // device pointer stands still at the hold addresses
  function holdAddr;
    input [6:0] a;
    begin
      holdAddr = (a == `SHP_DEV_HOLD_A) || (a == `SHP_DEV_FIFO_PORT) || (a == `SHP_DEV_HOLD_B);
    end
  endfunction

  reg  [2:0]  state;
  reg         cmdWrite;
  reg  [6:0]  cmdAddr;
  reg  [4:0]  cmdWords;
  reg         doneFlag;
  reg         refusedFlag;
  reg  [6:0]  devPtr;
  reg  [1:0]  modeReq;
  reg  [1:0]  modeNow;
  reg         sampleClkEn;
  reg  [7:0]  halfDiv;
  reg  [3:0]  bufIdx;
  reg         misoMeta;
  reg         misoSync;
  reg         inAddr;
  reg  [3:0]  bitCnt;
  reg  [3:0]  wordIdx;
  reg         lastBit;
  reg  [15:0] txShift;
  reg  [15:0] txWord;
  reg  [15:0] rxShift;
  reg         engWrEn;
  reg  [15:0] engWrData;
  wire        tick;
  wire [15:0] memRdata;
  wire        busy;
  wire        apbAccess;
  wire        apbWrite;
  wire        apbRead;
  wire        cmdHit;
  wire        bufHit;
  wire        startReq;
  wire        unsafeCmd;
  wire        memWrEn;
  wire [3:0]  memWrAddr;
  wire [15:0] memWrData;
  wire [3:0]  memRdAddr;
  wire [15:0] rxWord;
  wire [4:0]  cmdWordsIn;

  assign busy       = (state != ST_IDLE);
  assign apbAccess  = psel && penable && !pready;
  assign apbWrite   = apbAccess && pwrite;
  assign apbRead    = apbAccess && !pwrite;
  assign cmdHit     = (paddr == `SHP_REG_CMD);
  assign bufHit     = (paddr == `SHP_REG_BUFDATA);
  assign cmdWordsIn = pwdata[`SHP_CMD_WORDS_HI:`SHP_CMD_WORDS_LO];
  assign startReq   = apbWrite && cmdHit && pwdata[`SHP_CMD_START] && !busy;
  assign rxWord     = {rxShift[14:0], misoSync};

  // host-side guards on the mode machine; buffer word 0 is the first data word
  assign unsafeCmd = pwdata[`SHP_CMD_WRITE] && (
    ((pwdata[`SHP_CMD_ADDR_HI:`SHP_CMD_ADDR_LO] == `SHP_DEV_SCLK_CTRL) &&
     !memRdata[`SHP_DEV_CLKEN_BIT] && (modeNow != `SHP_MODE_STANDBY)) ||
    ((pwdata[`SHP_CMD_ADDR_HI:`SHP_CMD_ADDR_LO] == `SHP_DEV_STATUS) &&
     memRdata[`SHP_DEV_FCLR_BIT] && (modeNow != `SHP_MODE_PROGRAM)));

  // buffer ports: engine owns them while busy, software while idle
  assign memWrEn   = busy ? engWrEn : (apbWrite && bufHit);
  assign memWrAddr = busy ? wordIdx : bufIdx;
  assign memWrData = busy ? engWrData : pwdata[15:0];                       // slot setup words from software
  assign memRdAddr = busy ? wordIdx : (cmdHit ? 4'h0 : bufIdx);             // word 0 ready for the guard

  shp_word_mem u_mem (
    .sysClk (sys_clk),
    .clkEn  (clkEn),
    .wrEn   (memWrEn),
    .wrAddr (memWrAddr),
    .wrData (memWrData),
    .rdAddr (memRdAddr),
    .rdData (memRdata)
  );

  shp_sclk_gen u_sclk (
    .sysClk     (sys_clk),
    .resetN     (reset_n),
    .clkEn      (clkEn),
    .run        (busy),
    .halfPeriod (halfDiv),
    .tick       (tick)
  );

  // two-stage synchroniser for the device output
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      misoMeta <= 1'b0;
      misoSync <= 1'b0;
    end else if (clkEn) begin
      misoMeta <= spiMiso;
      misoSync <= misoMeta;
    end
  end

  // apb register file and answers, one wait state
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      halfDiv <= HALF_MIN;
      bufIdx  <= 4'h0;
    end else if (clkEn) begin
      pready  <= apbAccess;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apbAccess) begin
        case (paddr)
          `SHP_REG_CMD: begin
            prdata <= {11'h000, cmdWords, 1'b0, cmdAddr, 6'h00, cmdWrite, 1'b0};
            if (pwrite && busy) begin
              pslverr <= 1'b1;
            end
          end
          `SHP_REG_STATUS: begin
            prdata <= {13'h0000, sampleClkEn, modeNow, 1'b0, devPtr, 5'h00, refusedFlag, doneFlag, busy};
          end
          `SHP_REG_DIV: begin
            prdata <= {24'h000000, halfDiv};
            if (pwrite) begin
              halfDiv <= (pwdata[7:0] < HALF_MIN) ? HALF_MIN : pwdata[7:0];
            end
          end
          `SHP_REG_BUFIDX: begin
            prdata <= {28'h0000000, bufIdx};
            if (pwrite) begin
              bufIdx <= pwdata[3:0];
            end
          end
          `SHP_REG_BUFDATA: begin
            prdata <= {16'h0000, memRdata};
            if (busy) begin
              pslverr <= 1'b1;
            end else begin
              bufIdx <= bufIdx + 4'h1;
            end
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // sticky flags: set wins over a write-one clear
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      doneFlag    <= 1'b0;
      refusedFlag <= 1'b0;
    end else if (clkEn) begin
      if (state == ST_GAP && tick) begin
        doneFlag <= 1'b1;
      end else if (apbWrite && paddr == `SHP_REG_STATUS && pwdata[`SHP_ST_DONE]) begin
        doneFlag <= 1'b0;
      end
      if (startReq && (unsafeCmd || cmdWordsIn == 5'h00 || cmdWordsIn > 5'h10)) begin
        refusedFlag <= 1'b1;
      end else if (apbWrite && paddr == `SHP_REG_STATUS && pwdata[`SHP_ST_REFUSED]) begin
        refusedFlag <= 1'b0;
      end
    end
  end

  // shadow of the device mode machine, standby after reset
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      modeReq     <= `SHP_MODE_STANDBY;
      modeNow     <= `SHP_MODE_STANDBY;
      sampleClkEn <= 1'b0;
    end else if (clkEn) begin
      if (engWrEn && cmdWrite) begin
        if (devPtr == `SHP_DEV_MODE) begin
          modeReq <= txWord[1:0];
        end
        if (devPtr == `SHP_DEV_SCLK_CTRL) begin
          sampleClkEn <= txWord[`SHP_DEV_CLKEN_BIT];
        end
      end
      if (sampleClkEn) begin
        modeNow <= modeReq;
      end
    end
  end

  // serial engine
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      spiCsN    <= 1'b1;
      spiSclk   <= 1'b0;
      spiMosi   <= 1'b0;
      cmdWrite  <= 1'b0;
      cmdAddr   <= 7'h00;
      cmdWords  <= 5'h00;
      devPtr    <= 7'h00;
      inAddr    <= 1'b1;
      bitCnt    <= 4'h0;
      wordIdx   <= 4'h0;
      lastBit   <= 1'b0;
      txShift   <= 16'h0000;
      txWord    <= 16'h0000;
      rxShift   <= 16'h0000;
      engWrEn   <= 1'b0;
      engWrData <= 16'h0000;
    end else if (clkEn) begin
      engWrEn <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (startReq && !unsafeCmd && cmdWordsIn != 5'h00 && cmdWordsIn <= 5'h10) begin
            cmdWrite <= pwdata[`SHP_CMD_WRITE];
            cmdAddr  <= pwdata[`SHP_CMD_ADDR_HI:`SHP_CMD_ADDR_LO];
            cmdWords <= cmdWordsIn;
            devPtr   <= pwdata[`SHP_CMD_ADDR_HI:`SHP_CMD_ADDR_LO];
            // address MSB first, direction bit last
            txShift  <= {pwdata[`SHP_CMD_ADDR_HI - 1:`SHP_CMD_ADDR_LO], pwdata[`SHP_CMD_WRITE], 9'h000};
            spiMosi  <= pwdata[`SHP_CMD_ADDR_HI];
            spiCsN   <= 1'b0;
            inAddr   <= 1'b1;
            bitCnt   <= 4'h0;
            wordIdx  <= 4'h0;
            lastBit  <= 1'b0;
            state    <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick && !spiSclk) begin
            // rising edge: device samples mosi, host samples miso
            spiSclk <= 1'b1;
            rxShift <= rxWord;
            if (inAddr) begin
              if (bitCnt == 4'h7) begin
                inAddr <= 1'b0;
                bitCnt <= 4'h0;
              end else begin
                bitCnt <= bitCnt + 4'h1;
              end
            end else if (bitCnt == 4'hf) begin
              // whole word done; reads stored, writes counted as committed
              engWrEn   <= 1'b1;
              engWrData <= cmdWrite ? txWord : rxWord;
              bitCnt    <= 4'h0;
              if ({1'b0, wordIdx} == cmdWords - 5'h01) begin
                lastBit <= 1'b1;
              end
            end else begin
              bitCnt <= bitCnt + 4'h1;
            end
          end else if (tick && spiSclk) begin
            // falling edge: present next mosi bit
            spiSclk <= 1'b0;
            if (lastBit) begin
              spiMosi <= 1'b0;
              state   <= ST_TAIL;
            end else if (!inAddr && bitCnt == 4'h0) begin
              txWord  <= cmdWrite ? memRdata : 16'h0000;
              spiMosi <= cmdWrite & memRdata[15];
              txShift <= cmdWrite ? {memRdata[14:0], 1'b0} : 16'h0000;
            end else begin
              spiMosi <= txShift[15];
              txShift <= {txShift[14:0], 1'b0};
            end
          end
          // pointer follows the device after each whole word
          if (engWrEn) begin
            wordIdx <= wordIdx + 4'h1;
            if (!holdAddr(devPtr)) begin
              devPtr <= devPtr + 7'h01;
            end
          end
        end
        ST_TAIL: begin
          if (tick) begin
            spiCsN <= 1'b1;
            state  <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tick) begin
            inAddr <= 1'b1;
            bitCnt <= 4'h0;
            state  <= ST_IDLE;
          end
        end
        default: begin
          state  <= ST_IDLE;
          spiCsN <= 1'b1;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: shp_host_ctrl_properties.sv
`default_nettype none

module shp_host_ctrl_properties (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // serial link
  input wire logic        spiCsN,
  input wire logic        spiSclk,
  input wire logic        spiMosi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hiCnt;
  logic [7:0] loCnt;
  logic [9:0] riseCnt;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // phase lengths and rising edges per frame
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      hiCnt <= 8'h00;
      loCnt <= 8'h00;
      riseCnt <= 10'h000;
    end else begin
      hiCnt <= spiSclk ? hiCnt + 8'h01 : 8'h00;
      loCnt <= (spiSclk || loCnt == 8'hff) ? (spiSclk ? 8'h00 : loCnt) : loCnt + 8'h01;
      riseCnt <= spiCsN ? 10'h000 : riseCnt + {9'h000, $rose(spiSclk)};
    end
  end

  property p_sclkIdle;
    spiCsN |-> !spiSclk;
  endproperty
  a_sclkIdle: assert property (p_sclkIdle) else $error("serial clock active while deselected");

  property p_csHeld;
    spiSclk |=> !spiCsN;
  endproperty
  a_csHeld: assert property (p_csHeld) else $error("chip select rose too soon after clock high");

  property p_mosiHold;
    !spiCsN && spiSclk |-> $stable(spiMosi);
  endproperty
  a_mosiHold: assert property (p_mosiHold) else $error("mosi moved while clock high");

  property p_highMin;
    $fell(spiSclk) |-> hiCnt >= 8'd13;
  endproperty
  a_highMin: assert property (p_highMin) else $error("clock high phase too short");

  property p_lowMin;
    $rose(spiSclk) |-> loCnt >= 8'd13;
  endproperty
  a_lowMin: assert property (p_lowMin) else $error("clock low phase too short");

  property p_frameBits;
    $rose(spiCsN) |-> riseCnt >= 10'd24 && riseCnt[3:0] == 4'h8;
  endproperty
  a_frameBits: assert property (p_frameBits) else $error("frame is not header plus whole words");

  property p_readyWait;
    psel && penable && !pready |=> pready;
  endproperty
  a_readyWait: assert property (p_readyWait) else $error("apb answer not one cycle after access");

  property p_readyPulse;
    pready |=> !pready;
  endproperty
  a_readyPulse: assert property (p_readyPulse) else $error("ready held over two cycles");

  property p_readyCause;
    pready |-> $past(psel) && $past(penable);
  endproperty
  a_readyCause: assert property (p_readyCause) else $error("ready without an access");

  property p_quietData;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_quietData: assert property (p_quietData) else $error("read data or error outside answer");

  // main scenarios
  c_frame: cover property ($rose(spiCsN));
  c_burst: cover property ($rose(spiCsN) && riseCnt >= 10'd40);
  c_error: cover property (pready && pslverr);
endmodule

bind shp_host_ctrl shp_host_ctrl_properties i_shp_host_ctrl_properties (
  .sys_clk (sys_clk),
  .reset_n (reset_n),
  .psel    (psel),
  .penable (penable),
  .pready  (pready),
  .pslverr (pslverr),
  .prdata  (prdata),
  .spiCsN  (spiCsN),
  .spiSclk (spiSclk),
  .spiMosi (spiMosi)
);

`default_nettype wire

// file: shp_device_model.sv
`default_nettype none

module shp_device_model (
  // serial link
  input  wire logic csN,
  input  wire logic sclk,
  input  wire logic mosi,
  output var  logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs [0:127];
  logic [15:0] fifo [$];
  logic [15:0] sIn;
  logic [15:0] sOut;
  logic [15:0] req;
  logic [6:0]  ptr;
  logic [4:0]  bits;
  logic        hdr;
  logic        wr;
  logic        lock;
  logic        fifoIrq;

  // power-up in standby with the fifo full, 64 words queued
  initial begin
    for (int i = 0; i < 128; i++) regs[i] = 16'h0000;
    fifoIrq = 1'b0;
    pushPacket(32'h0000_5a00, 32'h0000_5a01, 1'b0);
    pushPacket(32'h0000_5a02, 32'h0000_5a03, 1'b0);
    pushPacket(32'h5a05_5a04, 32'h5a07_5a06, 1'b1);
    for (int i = 0; i < 30; i++) pushPacket(32'h0, 32'h0, 1'b0);
    req = 16'h0000;
    miso = 1'b0;
    lock = 1'b0;
    hdr = 1'b1;
    wr = 1'b1;
  end

  // word presented for a read, fifo port peeks only
  function automatic logic [15:0] rd(input logic [6:0] a);
    if (a == 7'h60) return fifo.size() ? fifo[0] : 16'h0000;
    if (a == 7'h00) return {8'(fifo.size() * 2), regs[0][7:0]};
    return regs[a];
  endfunction

  // register write side effects and mode machine
  task automatic wrReg(input logic [6:0] a, input logic [15:0] d);
    if (a == 7'h00) begin
      regs[0][7:0] = regs[0][7:0] & ~d[7:0];
      if (d[15]) fifo.delete();
    end else if (a == 7'h10) req = d;
    else regs[a] = d;
    if (a == 7'h4b && !d[7] && regs[7'h10] != 16'h0000) lock = 1'b1;
    if (regs[7'h4b][7] && !lock) regs[7'h10] = req;
  endtask

  // one packet per output data rate event, stored whole or dropped
  task automatic pushPacket(input logic [31:0] a, input logic [31:0] b, input logic wide);
    int n;
    n = wide ? 4 : 2;
    if ((fifo.size() + n) * 2 > 128) return;
    fifo.push_back(a[15:0]);
    if (wide) fifo.push_back(a[31:16]);
    fifo.push_back(b[15:0]);
    if (wide) fifo.push_back(b[31:16]);
    fifoIrq = 1'b1;
  endtask

  // frame start clears counters
  always @(negedge csN) begin
    hdr = 1'b1;
    bits = 5'h00;
  end

  // input sampled on rising clock
  always @(posedge sclk) if (!csN) begin
    sIn = {sIn[14:0], mosi};
    bits = bits + 5'h01;
    if (hdr && bits == 5'd8) begin
      ptr = sIn[7:1];
      wr = sIn[0];
      hdr = 1'b0;
      bits = 5'h00;
      sOut = rd(ptr);
    end else if (!hdr && bits == 5'd16) begin
      if (wr) wrReg(ptr, sIn);
      if (!wr && ptr == 7'h60 && fifo.size()) fifo.delete(0);
      if (!wr && ptr == 7'h60) fifoIrq = 1'b0;
      ptr = (ptr == 7'h5f || ptr == 7'h60 || ptr == 7'h7f) ? ptr : ptr + 7'h01;
      bits = 5'h00;
      sOut = rd(ptr);
    end
  end

  // output shifted on falling clock once a read is addressed
  always @(negedge sclk) if (!csN && !hdr && !wr) begin
    miso = sOut[15];
    sOut = {sOut[14:0], 1'b0};
  end

  // released line shows the inverted last level
  always @(posedge csN) miso = ~miso;
endmodule

`default_nettype wire

// file: shp_host_ctrl_test.sv
`include "shp_host_map.vh"
`default_nettype none

module shp_host_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FIFO_WORDS = 64;
  logic        sys_clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         spiCsN;
  wire         spiSclk;
  wire         spiMosi;
  wire         spiMiso;
  int          errors;
  int          total_checks;
  logic [31:0] seed;
  logic [31:0] rdv;
  logic [31:0] stat;
  logic        err;
  logic        busyErr;
  logic [31:0] wbuf [0:31];
  logic [31:0] rbuf [0:31];

  shp_host_ctrl i_shp_host_ctrl (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clkEn   (1'b1),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .spiCsN  (spiCsN),
    .spiSclk (spiSclk),
    .spiMosi (spiMosi),
    .spiMiso (spiMiso)
  );

  shp_device_model i_shp_device_model (
    .csN  (spiCsN),
    .sclk (spiSclk),
    .mosi (spiMosi),
    .miso (spiMiso)
  );

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 32'h0000ffff;
  endfunction

  // one apb transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // one device transaction through the command register
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [4:0] n);
    apb(1'b1, `SHP_REG_BUFIDX, 32'h0);
    for (int i = 0; i < n; i++) apb(1'b1, `SHP_REG_BUFDATA, wbuf[i]);
    apb(1'b1, `SHP_REG_CMD, {11'h000, n, 1'b0, a, 6'h00, wr, 1'b1});
    apb(1'b0, `SHP_REG_BUFDATA, 32'h0);
    busyErr = err;
    do apb(1'b0, `SHP_REG_STATUS, 32'h0); while (rdv[2:1] == 2'b00);
    stat = rdv;
    apb(1'b1, `SHP_REG_STATUS, 32'h6);
    apb(1'b1, `SHP_REG_BUFIDX, 32'h0);
    for (int i = 0; i < n; i++) begin
      apb(1'b0, `SHP_REG_BUFDATA, 32'h0);
      rbuf[i] = rdv;
    end
  endtask

  task automatic wr1(input logic [6:0] a, input logic [31:0] d);
    wbuf[0] = d;
    xfer(1'b1, a, 5'd1);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    summarize();
  end

  // main sequence
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'd89924;
    errors = 0;
    total_checks = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b1, `SHP_REG_DIV, 32'h5);
    apb(1'b0, `SHP_REG_DIV, 32'h0);
    chk(rdv, 32'd13, "div clamp");
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rdv, 32'h0, "unmapped data");
    apb(1'b0, `SHP_REG_STATUS, 32'h0);
    chk(rdv & 32'h70000, 32'h0, "status mode reset");
    // mode sequencing needs the sample clock enable
    xfer(1'b0, 7'h10, 5'd1);
    chk(rbuf[0], 32'h0, "mode power-up");
    wr1(7'h10, 32'h1);
    xfer(1'b0, 7'h10, 5'd1);
    chk(rbuf[0], 32'h0, "mode without clock");
    wr1(7'h4b, 32'h80);
    xfer(1'b0, 7'h10, 5'd1);
    chk(rbuf[0], 32'h1, "program mode");
    chk(stat & 32'h70000, 32'h50000, "shadow mode");
    // random bursts, full count and pointer hold
    for (int k = 0; k < 16; k++) wbuf[k] = rnd();
    xfer(1'b1, 7'h20, 5'd16);
    chk({31'h0, busyErr}, 32'h1, "busy buffer refused");
    xfer(1'b0, 7'h20, 5'd16);
    for (int k = 0; k < 16; k++) chk(rbuf[k], wbuf[k], "burst word");
    for (int k = 0; k < 4; k++) wbuf[k] = rnd();
    xfer(1'b1, 7'h5d, 5'd4);
    xfer(1'b0, 7'h5d, 5'd3);
    chk(rbuf[1], wbuf[1], "before hold");
    chk(rbuf[2], wbuf[3], "held address");
    chk(stat & 32'h7f00, 32'h5f00, "pointer hold");
    // fifo port pops words, status counts bytes
    xfer(1'b0, 7'h60, 5'd3);
    for (int k = 0; k < 3; k++) chk(rbuf[k], 32'h5a00 + 32'(k), "fifo word");
    xfer(1'b0, 7'h00, 5'd1);
    chk(rbuf[0] >> 8, 32'((FIFO_WORDS - 3) * 2), "fifo bytes");
    // normal mode refuses unsafe writes
    wr1(7'h10, 32'h2);
    xfer(1'b0, 7'h10, 5'd1);
    chk(rbuf[0], 32'h2, "normal mode");
    wr1(7'h4b, 32'h0);
    chk(stat & 32'h4, 32'h4, "clock stop refused");
    wr1(7'h00, 32'h80ff);
    chk(stat & 32'h4, 32'h4, "fifo clear refused");
    // stop sequence
    wr1(7'h10, 32'h1);
    wr1(7'h00, 32'h80ff);
    chk(stat & 32'h4, 32'h0, "fifo clear in program");
    xfer(1'b0, 7'h00, 5'd1);
    chk(rbuf[0] >> 8, 32'h0, "fifo emptied");
    wr1(7'h10, 32'h0);
    xfer(1'b0, 7'h10, 5'd1);
    chk(rbuf[0], 32'h0, "standby");
    wr1(7'h4b, 32'h0);
    chk(stat & 32'h4, 32'h0, "clock stop in standby");
    xfer(1'b1, 7'h20, 5'd0);
    chk(stat & 32'h4, 32'h4, "empty count refused");
    chk({31'h0, busyErr}, 32'h0, "idle buffer access");
    summarize();
  end
endmodule

`default_nettype wire
